// ==== hdl/twu_pkg.sv ====
// Constants, register map and state codes of the two-wire enable and clock unit.
// Assumes the AXI4-Lite byte address is four times the register index.
`default_nettype none

package twu_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned AXI_ADDR_W = 18;
  localparam logic [15:0] IDX_FIRST_CTL   = 16'hff62;
  localparam logic [15:0] IDX_STATUS      = 16'hff64;
  localparam logic [15:0] IDX_CTL_STATUS  = 16'hff66;
  localparam logic [15:0] IDX_ENABLE_DIVL = 16'hff6a;
  localparam logic [15:0] IDX_DIVH_ARP    = 16'hff6e;

  localparam logic [7:0] REG_RESET = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned EN_BIT      = 0;
  localparam int unsigned DIVL_LSB    = 1;
  localparam int unsigned DIVH_LSB    = 0;
  localparam int unsigned ARP_BIT     = 2;
  localparam int unsigned START_BIT   = 0;
  localparam int unsigned STOP_BIT    = 1;
  localparam int unsigned MASTER_BIT  = 0;
  localparam int unsigned MATCH_BIT   = 1;
  localparam int unsigned BB_BIT      = 0;
  localparam int unsigned SDA_BIT     = 1;
  localparam int unsigned TOGGLE_BIT  = 2;
  localparam int unsigned BUSY_BIT    = 3;
  localparam logic [2:0]  DIVH_ARP_MASK = 3'h7;

  // ****************************************************************
  // Bus constants and timing
  // ****************************************************************
  localparam logic [6:0]  ARP_ADDR      = 7'h61;
  localparam logic [1:0]  SCL_MULT_SHIFT = 2'h2;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [6:0] {
    ST_IDLE  = 7'h01,
    ST_START = 7'h02,
    ST_HOLD  = 7'h04,
    ST_TLO   = 7'h08,
    ST_THI   = 7'h10,
    ST_PLO   = 7'h20,
    ST_PHI   = 7'h40
  } twu_state_type;

  function automatic logic [AXI_ADDR_W-1:0] byte_addr(input logic [15:0] idx);
    return {idx, 2'h0};
  endfunction

endpackage

`default_nettype wire

// ==== hdl/twu_sync.sv ====
// Two-flop level synchroniser into the destination clock.
// Assumes the input is a level that holds for more than one destination clock.
`default_nettype none

module twu_sync
  import twu_pkg::*;
(
  input  wire logic clk,
  input  wire logic d,
  output var  logic q
);

  logic meta_reg;

  always_ff @(posedge clk) begin
    meta_reg <= d;
  end

  always_ff @(posedge clk) begin
    q <= meta_reg;
  end

endmodule

`default_nettype wire

// ==== hdl/twu_link_mon.sv ====
// Line watcher on the link clock: finds start and stop conditions on the wires.
// Assumes the link clock samples the wires several times per bus bit.
`default_nettype none

module twu_link_mon
  import twu_pkg::*;
(
  input  wire logic link_clk,
  input  wire logic aresetn,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output var  logic start_tgl,
  output var  logic stop_tgl
);

  logic rst_m_reg;
  logic rst_n_reg;
  logic scl_m_reg;
  logic scl_s_reg;
  logic sda_m_reg;
  logic sda_s_reg;
  logic sda_d_reg;

  // Reset and wires are foreign here, so each passes two flops first.
  always_ff @(posedge link_clk) begin
    rst_m_reg <= aresetn;
    rst_n_reg <= rst_m_reg;
    scl_m_reg <= scl_i;
    scl_s_reg <= scl_m_reg;
    sda_m_reg <= sda_i;
    sda_s_reg <= sda_m_reg;
    sda_d_reg <= sda_s_reg;
  end

  // Events leave as toggles so the core clock can never miss one.
  always_ff @(posedge link_clk) begin
    if (!rst_n_reg) begin
      start_tgl <= 1'b0;
      stop_tgl  <= 1'b0;
    end else begin
      if (scl_s_reg && sda_d_reg && !sda_s_reg) begin
        start_tgl <= !start_tgl;
      end
      if (scl_s_reg && !sda_d_reg && sda_s_reg) begin
        stop_tgl <= !stop_tgl;
      end
    end
  end

endmodule

`default_nettype wire

// ==== hdl/twu_top.sv ====
// Enable, bit-rate and bus-busy part of a two-wire bus unit, with an AXI4-Lite slave.
// Assumes open-drain pads outside and a free-running link clock for the line watcher.
`default_nettype none

module twu_top
  import twu_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  link_clk,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  input  wire logic                  scl_i,
  output logic                       scl_o,
  output logic                       scl_oe,
  input  wire logic                  sda_i,
  output logic                       sda_o,
  output logic                       sda_oe,
  input  wire logic                  addr_byte_valid,
  input  wire logic [6:0]            addr_byte,
  output logic                       module_enable,
  output logic                       bus_busy_flag,
  output logic                       master,
  output logic                       arp_match_pulse
);

  // ****************************************************************
  // State and wires
  // ****************************************************************
  logic [7:0]            ctl2_reg;
  logic [7:0]            ctl3_reg;
  logic [7:0]            ctl1_reg;
  logic                  master_reg;
  logic                  match_reg;
  logic                  bb_reg;
  logic                  arp_reg;
  twu_state_type         state_reg;
  twu_state_type         state_next;
  logic [10:0]           cnt_reg;
  logic [10:0]           half_w;
  logic                  cnt_done;
  logic                  aw_hold_reg;
  logic                  w_hold_reg;
  logic [AXI_ADDR_W-1:0] awaddr_reg;
  logic [7:0]            wdata_reg;
  logic                  wstrb_reg;
  logic                  bvalid_reg;
  logic [1:0]            bresp_reg;
  logic                  rvalid_reg;
  logic [31:0]           rdata_reg;
  logic [1:0]            rresp_reg;
  logic [31:0]           rdata_next;
  logic                  rerr_next;
  logic                  do_write;
  logic                  wr_ctl1;
  logic                  wr_st;
  logic                  wr_cst;
  logic                  wr_ctl2;
  logic                  wr_ctl3;
  logic                  wr_err;
  logic                  sda_sense;
  logic                  start_tgl;
  logic                  stop_tgl;
  logic                  start_tgl_s;
  logic                  stop_tgl_s;
  logic                  start_tgl_d_reg;
  logic                  stop_tgl_d_reg;
  logic                  line_start;
  logic                  line_stop;
  logic                  enable;
  logic                  toggle_req;
  logic                  arp_hit;

  function automatic logic [10:0] half_cycles(input logic [1:0] hi, input logic [6:0] lo);
    return 11'({hi, lo}) << SCL_MULT_SHIFT;
  endfunction

  assign enable   = ctl2_reg[EN_BIT];
  assign half_w   = half_cycles(ctl3_reg[DIVH_LSB +: 2], ctl2_reg[DIVL_LSB +: 7]);
  assign cnt_done = (cnt_reg == 11'h000);

  // ****************************************************************
  // Line watcher and crossings
  // ****************************************************************
  twu_link_mon u_mon (
    .link_clk  (link_clk),
    .aresetn   (aresetn),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .start_tgl (start_tgl),
    .stop_tgl  (stop_tgl)
  );

  twu_sync u_sda   (.clk(aclk), .d(sda_i),     .q(sda_sense));
  twu_sync u_start (.clk(aclk), .d(start_tgl), .q(start_tgl_s));
  twu_sync u_stop  (.clk(aclk), .d(stop_tgl),  .q(stop_tgl_s));

  always_ff @(posedge aclk) begin
    start_tgl_d_reg <= start_tgl_s;
    stop_tgl_d_reg  <= stop_tgl_s;
  end

  assign line_start = start_tgl_s ^ start_tgl_d_reg;
  assign line_stop  = stop_tgl_s ^ stop_tgl_d_reg;

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign do_write      = aw_hold_reg && w_hold_reg && !bvalid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wdata_reg   <= REG_RESET;
      wstrb_reg   <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg  <= s_axi_wdata[7:0];
        wstrb_reg  <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_hold_reg <= 1'b0;
        w_hold_reg  <= 1'b0;
        bvalid_reg  <= 1'b1;
        bresp_reg   <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // Only the low byte lane carries data; a write without it changes nothing.
  always_comb begin
    wr_ctl1 = 1'b0;
    wr_st   = 1'b0;
    wr_cst  = 1'b0;
    wr_ctl2 = 1'b0;
    wr_ctl3 = 1'b0;
    wr_err  = 1'b0;
    if (awaddr_reg == byte_addr(IDX_FIRST_CTL)) begin
      wr_ctl1 = do_write && wstrb_reg;
    end else if (awaddr_reg == byte_addr(IDX_STATUS)) begin
      wr_st = do_write && wstrb_reg;
    end else if (awaddr_reg == byte_addr(IDX_CTL_STATUS)) begin
      wr_cst = do_write && wstrb_reg;
    end else if (awaddr_reg == byte_addr(IDX_ENABLE_DIVL)) begin
      wr_ctl2 = do_write && wstrb_reg;
    end else if (awaddr_reg == byte_addr(IDX_DIVH_ARP)) begin
      wr_ctl3 = do_write && wstrb_reg;
    end else begin
      wr_err = 1'b1;
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    rerr_next  = 1'b0;
    if (s_axi_araddr == byte_addr(IDX_FIRST_CTL)) begin
      rdata_next[7:0] = ctl1_reg;
    end else if (s_axi_araddr == byte_addr(IDX_STATUS)) begin
      rdata_next[MASTER_BIT] = master_reg;
      rdata_next[MATCH_BIT]  = match_reg;
    end else if (s_axi_araddr == byte_addr(IDX_CTL_STATUS)) begin
      rdata_next[BB_BIT]     = bb_reg;
      rdata_next[SDA_BIT]    = sda_sense;
      rdata_next[TOGGLE_BIT] = (state_reg == ST_TLO) || (state_reg == ST_THI);
      rdata_next[BUSY_BIT]   = (state_reg != ST_IDLE) && (state_reg != ST_HOLD);
    end else if (s_axi_araddr == byte_addr(IDX_ENABLE_DIVL)) begin
      rdata_next[7:0] = ctl2_reg;
    end else if (s_axi_araddr == byte_addr(IDX_DIVH_ARP)) begin
      rdata_next[7:0] = ctl3_reg;
    end else begin
      rerr_next = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rerr_next ? RESP_SLVERR : RESP_OKAY;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // cleared while disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl2_reg <= REG_RESET;
    end else if (wr_ctl2) begin
      ctl2_reg <= wdata_reg[EN_BIT] ? wdata_reg : REG_RESET;
    end
  end

  // Reserved bits are never stored, so they read back as zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl3_reg <= REG_RESET;
    end else if (wr_ctl3) begin
      ctl3_reg <= {5'h00, wdata_reg[2:0] & DIVH_ARP_MASK};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      ctl1_reg <= REG_RESET;
    end else begin
      if (wr_ctl1 && wdata_reg[START_BIT]) begin
        ctl1_reg[START_BIT] <= 1'b1;
      end else if (state_reg == ST_START && cnt_done) begin
        ctl1_reg[START_BIT] <= 1'b0;
      end
      if (wr_ctl1 && wdata_reg[STOP_BIT] && master_reg) begin
        ctl1_reg[STOP_BIT] <= 1'b1;
      end else if (state_reg == ST_PHI && cnt_done) begin
        ctl1_reg[STOP_BIT] <= 1'b0;
      end
    end
  end

  // bus busy held clear when disabled
  // A line start in the same cycle as a software clear wins.
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      bb_reg <= 1'b0;
    end else if (line_start) begin
      bb_reg <= 1'b1;
    end else if (line_stop || (wr_cst && wdata_reg[BB_BIT])) begin
      bb_reg <= 1'b0;
    end
  end

  // ARP address match in slave mode
  assign arp_hit = enable && ctl3_reg[ARP_BIT] && !master_reg && addr_byte_valid
                   && (addr_byte == ARP_ADDR);

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      match_reg <= 1'b0;
      arp_reg   <= 1'b0;
    end else begin
      arp_reg <= arp_hit;
      if (arp_hit) begin
        match_reg <= 1'b1;
      end else if (wr_st && wdata_reg[MATCH_BIT]) begin
        match_reg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // SCL and SDA sequencer
  // ****************************************************************
  assign toggle_req = wr_cst && wdata_reg[TOGGLE_BIT];

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // start once the bus is free
        if (ctl1_reg[START_BIT] && !bb_reg) begin
          state_next = ST_START;
        end else if (toggle_req) begin
          state_next = ST_TLO;
        end
      end
      ST_START: if (cnt_done) begin
        state_next = ST_HOLD;
      end
      ST_HOLD: if (ctl1_reg[STOP_BIT]) begin
        state_next = ST_PLO;
      end
      ST_TLO: if (cnt_done) begin
        state_next = ST_THI;
      end
      ST_THI: if (cnt_done) begin
        state_next = ST_IDLE;
      end
      ST_PLO: if (cnt_done) begin
        state_next = ST_PHI;
      end
      ST_PHI: if (cnt_done) begin
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 11'h000;
    end else begin
      state_reg <= state_next;
      if (state_next != state_reg) begin
        cnt_reg <= half_w - 11'h001;
      end else if (!cnt_done) begin
        cnt_reg <= cnt_reg - 11'h001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      master_reg <= 1'b0;
    end else if (state_reg == ST_START && cnt_done) begin
      master_reg <= 1'b1;
    end else if (state_reg == ST_PHI && cnt_done) begin
      master_reg <= 1'b0;
    end
  end

  // SCL released unless this unit clocks
  // Pads are open drain: the unit only ever pulls low.
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      scl_oe <= (state_next == ST_HOLD) || (state_next == ST_TLO) || (state_next == ST_PLO);
      sda_oe <= (state_next == ST_START) || (state_next == ST_HOLD)
                || (state_next == ST_PLO) || (state_next == ST_PHI);
    end
  end

  assign scl_o           = 1'b0;
  assign sda_o           = 1'b0;
  assign module_enable   = enable;
  assign bus_busy_flag   = bb_reg;
  assign master          = master_reg;
  assign arp_match_pulse = arp_reg;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [10:0] dwell_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn || state_next != state_reg) begin
      dwell_reg <= 11'h000;
    end else begin
      dwell_reg <= dwell_reg + 11'h001;
    end
  end

  sequence toggle_low_s;
    state_reg == ST_TLO ##1 state_reg == ST_THI;
  endsequence

  ctl2_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !enable |-> ctl2_reg == 8'h00) else $error("control two not clear while disabled");
  disable_clr_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(enable) |=> ctl1_reg == 8'h00 && !master_reg && !match_reg && !bb_reg
    && state_reg == ST_IDLE) else $error("disable left state behind");
  scl_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
    toggle_low_s |-> $past(dwell_reg) == {ctl3_reg[1:0], ctl2_reg[7:1], 2'h0} - 11'h001)
    else $error("SCL low time wrong");
  scl_high_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_THI ##1 state_reg == ST_IDLE |-> $past(dwell_reg) == half_w - 11'h001)
    else $error("SCL high time differs from low time");
  arp_match_a: assert property (@(posedge aclk) disable iff (!aresetn)
    enable && addr_byte_valid && addr_byte == 7'h61 && !master_reg
    |=> match_reg == $past(ctl3_reg[2]) || $past(match_reg))
    else $error("ARP match wrong");
  bb_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !enable |=> !bb_reg) else $error("bus busy set while disabled");
  sda_sense_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ##2 sda_sense == $past(sda_i, 2)) else $error("SDA sense not tracking line");
  one_toggle_a: assert property (@(posedge aclk) disable iff (!aresetn)
    state_reg == ST_THI ##1 state_reg != ST_THI |-> state_reg == ST_IDLE ##1
    state_reg != ST_TLO) else $error("toggle gave more than one cycle");
  start_go_a: assert property (@(posedge aclk) disable iff (!aresetn)
    enable && state_reg == ST_IDLE && ctl1_reg[0] && !bb_reg |=> state_reg == ST_START)
    else $error("pending start not issued");
  stop_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $fell(state_reg == ST_PHI) |-> !ctl1_reg[1] && !master_reg && !sda_oe)
    else $error("stop bit did not self clear");
  scl_free_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !enable |=> !scl_oe && !sda_oe) else $error("line held while disabled");

endmodule

`default_nettype wire

// ==== testbench/twu_line_model.sv ====
// Far side of the two-wire bus: pull-ups and a slave that can hold SDA low.
// Assumes the block drives both pads open-drain through its enables.
`default_nettype none
module twu_line_model (
  input  wire logic scl_oe,
  input  wire logic sda_oe,
  input  wire logic hold_sda,
  output wire logic scl,
  output wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  assign scl = !scl_oe;
  assign sda = !(sda_oe || hold_sda);
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the two-wire enable and bit-rate block.
// Assumes twu_line_model as far side and divisor 8, so one phase is 32 cycles.
`default_nettype none
module tb
  import twu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0, link_clk = 1'b0, aresetn = 1'b0, hold_sda = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, abv = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic [17:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, v, seed = 32'h0000d65e;
  logic [3:0]  wstrb = 4'h0;
  logic [6:0]  abyte = 7'h00;
  logic [1:0]  bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, scl, sda, scl_o, sda_o;
  logic        scl_oe, sda_oe, men, bbf, mst, arp, st_gap;
  logic [33:0] expq[$];
  int          error_cnt = 0, checks = 0, arp_cnt = 0, n, gap_cnt = 0, gap_last = 0;
  int          pull_cnt = 0, pull_last = 0;

  twu_top DUT (.aclk(aclk), .aresetn(aresetn), .link_clk(link_clk),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_i(scl), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .addr_byte_valid(abv), .addr_byte(abyte), .module_enable(men),
    .bus_busy_flag(bbf), .master(mst), .arp_match_pulse(arp));
  twu_line_model bus (.scl_oe(scl_oe), .sda_oe(sda_oe), .hold_sda(hold_sda),
    .scl(scl), .sda(sda));

  always #25 aclk = ~aclk;
  initial begin
    #13;
    forever #40 link_clk = ~link_clk;
  end
  assign st_gap = sda_oe && !scl_oe;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [33:0] okv(input logic [7:0] d);
    return {RESP_OKAY, 24'h000000, d};
  endfunction

  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask

  // Phase lengths are measured here, since a phase may begin before a write returns.
  always @(posedge aclk) begin
    gap_cnt <= st_gap ? gap_cnt + 1 : 0;
    pull_cnt <= scl_oe ? pull_cnt + 1 : 0;
    if (!st_gap && gap_cnt != 0) gap_last <= gap_cnt;
    if (!scl_oe && pull_cnt != 0) pull_last <= pull_cnt;
    if (arp === 1'b1) arp_cnt <= arp_cnt + 1;
    if (rvalid && rready) chk("read", expq.pop_front(), {rresp, rdata});
  end

  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= (rnd() << 8) | {24'h000000, d};
    wstrb <= 4'h1;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] idx, input logic [33:0] e);
    expq.push_back(e);
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
  endtask

  task automatic arp_try(input logic [6:0] a, input logic [33:0] e);
    n = arp_cnt;
    @(posedge aclk);
    abv <= 1'b1;
    abyte <= a;
    @(posedge aclk);
    abv <= 1'b0;
    repeat (4) @(posedge aclk);
    chk("arp match count", e, 34'(arp_cnt - n));
  endtask

  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    test_done();
  end

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(IDX_ENABLE_DIVL, okv(8'h00));
    rd(IDX_DIVH_ARP, okv(8'h00));
    wr(IDX_ENABLE_DIVL, 8'h16);
    rd(IDX_ENABLE_DIVL, okv(8'h00));
    v = rnd();
    wr(IDX_DIVH_ARP, v[7:0]);
    rd(IDX_DIVH_ARP, okv(v[7:0] & 8'h07));
    wr(IDX_DIVH_ARP, 8'h04);
    wr(IDX_ENABLE_DIVL, 8'h11);
    chk("write response", {32'h00000000, RESP_OKAY}, {32'h00000000, bresp});
    rd(IDX_ENABLE_DIVL, okv(8'h11));
    $display("test registers done");
    rd(IDX_CTL_STATUS, okv(8'h02));
    wr(IDX_CTL_STATUS, 8'h04);
    repeat (80) @(posedge aclk);
    chk("toggle low time", 34'd32, 34'(pull_last));
    rd(IDX_CTL_STATUS, okv(8'h02));
    arp_try(7'h61, 34'd1);
    rd(IDX_CTL_STATUS, okv(8'h02));
    rd(IDX_STATUS, okv(8'h02));
    wr(IDX_DIVH_ARP, 8'h00);
    arp_try(7'h61, 34'd0);
    $display("test toggle and match done");
    repeat (40) @(posedge aclk);
    rd(IDX_CTL_STATUS, okv(8'h02));
    wr(IDX_FIRST_CTL, 8'h01);
    repeat (60) @(posedge aclk);
    chk("start high time", 34'd32, 34'(gap_last));
    chk("master", 34'd1, 34'(mst));
    chk("bus busy", 34'd1, 34'(bbf));
    wr(IDX_FIRST_CTL, 8'h02);
    repeat (90) @(posedge aclk);
    chk("stop high time", 34'd32, 34'(gap_last));
    chk("master", 34'd0, 34'(mst));
    chk("bus busy", 34'd0, 34'(bbf));
    rd(IDX_FIRST_CTL, okv(8'h00));
    $display("test start and stop done");
    hold_sda <= 1'b1;
    repeat (30) @(posedge aclk);
    rd(IDX_CTL_STATUS, okv(8'h01));
    wr(IDX_FIRST_CTL, 8'h01);
    wr(IDX_CTL_STATUS, 8'h04);
    rd(IDX_CTL_STATUS, okv(8'h0d));
    repeat (80) @(posedge aclk);
    chk("master", 34'd0, 34'(mst));
    rd(IDX_CTL_STATUS, okv(8'h01));
    wr(IDX_CTL_STATUS, 8'h01);
    repeat (80) @(posedge aclk);
    chk("master", 34'd1, 34'(mst));
    wr(IDX_ENABLE_DIVL, 8'h10);
    repeat (2) @(posedge aclk);
    chk("master", 34'd0, 34'(mst));
    chk("bus busy", 34'd0, 34'(bbf));
    chk("enable", 34'd0, 34'(men));
    rd(IDX_FIRST_CTL, okv(8'h00));
    rd(IDX_STATUS, okv(8'h00));
    rd(IDX_ENABLE_DIVL, okv(8'h00));
    wr(IDX_ENABLE_DIVL, 8'h11);
    repeat (20) @(posedge aclk);
    chk("bus busy", 34'd0, 34'(bbf));
    hold_sda <= 1'b0;
    rd(16'h0001, {RESP_SLVERR, 32'h00000000});
    wr(16'h0001, 8'h01);
    chk("write response", {32'h00000000, RESP_SLVERR}, {32'h00000000, bresp});
    chk("pad drive levels", 34'd0, 34'({scl_o, sda_o}));
    $display("test recovery done");
    test_done();
  end
endmodule
`default_nettype wire
